// file: rtl/sample_queue_modes.sv
// Overview of operation
// - 32-entry queue, mode field selects behaviour
// - bypass mode stores nothing, queue empty
// - watermark holds while count reaches samples field
// - fill-once stops writing at 32 entries
// - stream keeps newest 32, drops oldest
// - trigger keeps newest 32, event to pin
// - on trigger trim to n, then fill-once
// - one trigger only; bypass then trigger re-arms
// - selecting bypass flushes the ring, head register keeps its entry
// - data reads return queue, pop loads oldest
// - single-byte read loses rest of entry
// - read ends at 0x37-to-0x38 or chip-select high
// - overrun sets on full, clears on read
// - watermark clears when reads drop count below
`timescale 1ns/100ps
`default_nettype none

module sample_queue_modes (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // measurement samples
  input  wire logic        sample_valid,
  input  wire logic [15:0] meas_x,
  input  wire logic [15:0] meas_y,
  input  wire logic [15:0] meas_z,
  // trigger event source
  input  wire logic        trigger_event,
  // register port from serial interface
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // serial chip select pin
  input  wire logic        cs_n,
  // event outputs
  output logic             event_pin_one,
  output logic             event_pin_two,
  output logic             watermark,
  output logic             overrun
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [47:0] out;
    logic        out_valid;
    logic        triggered;
    logic        trimming;
    logic        touched;
    logic        overrun;
    logic        watermark;
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_prev;
    logic        pin_one;
    logic        pin_two;
    logic [7:0]  rdata;
  } queue_state_type;

  queue_state_type cur_ff;
  queue_state_type nxt_ff;

  // ring storage signals
  logic [47:0] head_data;
  logic [5:0]  ring_level;
  logic        ring_flush;
  logic        ring_push;
  logic        ring_pop;

  // decoded conditions
  sample_queue_pkg::queue_mode_type mode;
  logic        storing;
  logic        fill_only;
  logic [5:0]  keep_n;
  logic [5:0]  total;
  logic        full;
  logic        cs_rise;
  logic        data_rd;
  logic        pop_req;
  logic        trig_hit;
  logic        drop;
  logic        consume;
  logic [7:0]  data_off;
  logic [47:0] data_shift;

  sample_ring #(
    .W     (sample_queue_pkg::ENTRY_W),
    .DEPTH (sample_queue_pkg::DEPTH),
    .AW    (sample_queue_pkg::LEVEL_W - 1)
  ) sample_ring_i (
    .mclk      (mclk),
    .rstn      (rstn),
    .flush     (ring_flush),
    .push      (ring_push),
    .push_data ({meas_z, meas_y, meas_x}),
    .pop       (ring_pop),
    .head_data (head_data),
    .level     (ring_level)
  );

  // mode and level decode
  always_comb begin
    mode      = sample_queue_pkg::queue_mode_type'(
                  cur_ff.ctl[sample_queue_pkg::MODE_MSB:sample_queue_pkg::MODE_LSB]);
    storing   = (mode != sample_queue_pkg::MODE_BYPASS);
    fill_only = (mode == sample_queue_pkg::MODE_FILL) ||
                ((mode == sample_queue_pkg::MODE_TRIGGER) && cur_ff.triggered);
    keep_n    = {1'b0, cur_ff.ctl[sample_queue_pkg::SAMPLES_MSB:0]};
    // bypass head register is not a queue entry, so the count stays zero there
    total     = ring_level + {5'h0, cur_ff.out_valid && storing};
    full      = (total == sample_queue_pkg::DEPTH_LEVEL);
  end

  // read completion and pop request
  always_comb begin
    cs_rise = cur_ff.cs_s2 & ~cur_ff.cs_prev;
    data_rd = reg_rd && (reg_addr >= sample_queue_pkg::DATA_FIRST_ADDR) &&
              (reg_addr <= sample_queue_pkg::DATA_LAST_ADDR);
    // a touched entry is done at the step to 0x38 or chip-select high
    pop_req = cur_ff.touched &&
              ((reg_rd && (reg_addr == sample_queue_pkg::CTL_ADDR)) || cs_rise);
    trig_hit = trigger_event && (mode == sample_queue_pkg::MODE_TRIGGER) &&
               !cur_ff.triggered;
  end

  // queue write, discard and head load
  always_comb begin
    drop = storing &&
           ((sample_valid && full && !fill_only) ||
            (cur_ff.trimming && (total > keep_n)));
    consume    = pop_req || drop;
    ring_flush = !storing;
    ring_push  = storing && sample_valid && (!full || drop) && !(full && fill_only);
    ring_pop   = storing && (ring_level != 6'h00) && (consume || !cur_ff.out_valid);
  end

  // data register byte select
  always_comb begin
    data_off   = reg_addr - sample_queue_pkg::DATA_FIRST_ADDR;
    data_shift = cur_ff.out >> {data_off[2:0], 3'h0};
  end

  // next state
  always_comb begin
    nxt_ff = cur_ff;

    // chip select synchroniser and edge history
    nxt_ff.cs_s1   = cs_n;
    nxt_ff.cs_s2   = cur_ff.cs_s1;
    nxt_ff.cs_prev = cur_ff.cs_s2;

    // an entry counts as touched from its first data byte read
    nxt_ff.touched = data_rd || (cur_ff.touched && !pop_req);

    if (reg_wr && (reg_addr == sample_queue_pkg::CTL_ADDR)) begin
      nxt_ff.ctl = reg_wdata;
    end

    if (!storing) begin
      // bypass: data registers follow the newest sample
      nxt_ff.triggered = 1'b0;
      nxt_ff.trimming  = 1'b0;
      nxt_ff.watermark = 1'b0;
      if (pop_req) begin
        nxt_ff.out_valid = 1'b0;
      end
      if (sample_valid) begin
        nxt_ff.out       = {meas_z, meas_y, meas_x};
        nxt_ff.out_valid = 1'b1;
        if (cur_ff.out_valid && !pop_req) begin
          nxt_ff.overrun = 1'b1;
        end
      end
      if (pop_req && !(sample_valid && cur_ff.out_valid)) begin
        nxt_ff.overrun = 1'b0;
      end
    end else begin
      // head entry loaded from the ring when consumed or empty
      if (consume || !cur_ff.out_valid) begin
        if (ring_level != 6'h00) begin
          nxt_ff.out       = head_data;
          nxt_ff.out_valid = 1'b1;
        end else if (consume) begin
          nxt_ff.out_valid = 1'b0;
        end
      end
      // trigger capture and trim down to n newest
      if (trig_hit) begin
        nxt_ff.triggered = 1'b1;
        nxt_ff.trimming  = 1'b1;
      end else if (cur_ff.trimming && (total <= keep_n)) begin
        nxt_ff.trimming  = 1'b0;
      end
      // overrun: reaching full sets, a read clears, set wins
      if (pop_req) begin
        nxt_ff.overrun = 1'b0;
      end
      if (ring_push && !drop && (total == sample_queue_pkg::DEPTH_LEVEL - 6'h01)) begin
        nxt_ff.overrun = 1'b1;
      end
      // watermark level follows count against samples field
      nxt_ff.watermark = (total >= keep_n);
    end

    // trigger routed to the pin chosen by the control bit
    nxt_ff.pin_one = nxt_ff.triggered && !nxt_ff.ctl[sample_queue_pkg::TRIG_PIN];
    nxt_ff.pin_two = nxt_ff.triggered && nxt_ff.ctl[sample_queue_pkg::TRIG_PIN];

    // register read data
    if (reg_rd) begin
      if (data_rd) begin
        nxt_ff.rdata = data_shift[7:0];
      end else if (reg_addr == sample_queue_pkg::CTL_ADDR) begin
        nxt_ff.rdata = cur_ff.ctl;
      end else if (reg_addr == sample_queue_pkg::STATE_ADDR) begin
        nxt_ff.rdata = {cur_ff.triggered, 1'b0, total};
      end else begin
        nxt_ff.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cur_ff         <= '0;
      cur_ff.ctl     <= sample_queue_pkg::CTL_RESET;
      cur_ff.cs_s1   <= 1'b1;
      cur_ff.cs_s2   <= 1'b1;
      cur_ff.cs_prev <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata     = cur_ff.rdata;
  assign event_pin_one = cur_ff.pin_one;
  assign event_pin_two = cur_ff.pin_two;
  assign watermark     = cur_ff.watermark;
  assign overrun       = cur_ff.overrun;

endmodule : sample_queue_modes

`default_nettype wire

// file: rtl/sample_queue_pkg.sv
package sample_queue_pkg;

  // register byte addresses
  localparam logic [7:0] DATA_FIRST_ADDR = 8'h32;
  localparam logic [7:0] DATA_LAST_ADDR  = 8'h37;
  localparam logic [7:0] CTL_ADDR        = 8'h38;
  localparam logic [7:0] STATE_ADDR      = 8'h39;

  // queue geometry
  localparam int         AXIS_W      = 16;
  localparam int         ENTRY_W     = 48;
  localparam int         DEPTH       = 32;
  localparam int         LEVEL_W     = 6;
  localparam logic [5:0] DEPTH_LEVEL = 6'h20;

  // control register layout and reset
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam int         MODE_MSB    = 7;
  localparam int         MODE_LSB    = 6;
  localparam int         TRIG_PIN    = 5;
  localparam int         SAMPLES_MSB = 4;

  // status register layout
  localparam int         STATE_TRIG_BIT = 7;

  // queue modes
  typedef enum logic [1:0] {
    MODE_BYPASS  = 2'h0,
    MODE_FILL    = 2'h1,
    MODE_STREAM  = 2'h2,
    MODE_TRIGGER = 2'h3
  } queue_mode_type;

endpackage : sample_queue_pkg

// file: rtl/sample_ring.sv
`timescale 1ns/100ps
`default_nettype none

module sample_ring #(
  parameter int W     = 48,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rstn,
  // control
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  // state
  output logic      [W-1:0]  head_data,
  output logic      [AW:0]   level
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             level;
  } ring_state_type;

  ring_state_type cur_ff;
  ring_state_type nxt_ff;

  localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

  // pointer and level update, push blocked when full without pop or on flush
  always_comb begin
    logic do_push;
    logic do_pop;
    do_push = 1'b0;
    do_pop  = 1'b0;
    nxt_ff  = cur_ff;
    do_pop  = pop && (cur_ff.level != '0);
    do_push = push && ((cur_ff.level != FULL_LEVEL) || do_pop);
    if (flush) begin
      nxt_ff.wr_ptr = '0;
      nxt_ff.rd_ptr = '0;
      nxt_ff.level  = '0;
    end else begin
      if (do_push) begin
        nxt_ff.mem[cur_ff.wr_ptr] = push_data;
        nxt_ff.wr_ptr             = cur_ff.wr_ptr + 1'b1;
      end
      if (do_pop) begin
        nxt_ff.rd_ptr = cur_ff.rd_ptr + 1'b1;
      end
      nxt_ff.level = cur_ff.level + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign head_data = cur_ff.mem[cur_ff.rd_ptr];
  assign level     = cur_ff.level;

endmodule : sample_ring

`default_nettype wire

// file: test/sample_queue_props.sv
`timescale 1ns/100ps
`default_nettype none
module sample_queue_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // watched ports
  input wire logic       trigger_event,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       event_pin_one,
  input wire logic       event_pin_two,
  input wire logic       watermark
);
  logic [7:0] ctl_ff;
  logic [1:0] md;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // shadow of the control register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ctl_ff <= 8'h00;
    else if (reg_wr && reg_addr == sample_queue_pkg::CTL_ADDR) ctl_ff <= reg_wdata;
  end
  assign md = ctl_ff[7:6];
  // register port answers
  unmapped_zero_a: assert property (
    reg_rd && (reg_addr < 8'h32 || reg_addr > 8'h39) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctl_readback_a: assert property (
    reg_rd && reg_addr == 8'h38 |=> reg_rdata == $past(ctl_ff))
    else $error("control readback wrong");
  state_bit6_a: assert property (
    reg_rd && reg_addr == 8'h39 |=> !reg_rdata[6])
    else $error("status bit 6 set");
  // levels against the selected mode
  bypass_nowm_a: assert property ((md == 2'h0) [*3] |-> !watermark)
    else $error("watermark in bypass");
  bypass_nopin_a: assert property (
    (md == 2'h0) [*3] |-> !event_pin_one && !event_pin_two)
    else $error("event pin high in bypass");
  zero_level_wm_a: assert property (
    (md != 2'h0 && ctl_ff[4:0] == 5'h00) [*3] |-> watermark)
    else $error("watermark low with zero level");
  // trigger routing and one-shot hold
  trig_route_a: assert property (
    md == 2'h3 && trigger_event && !reg_wr && !event_pin_one && !event_pin_two
    |=> event_pin_two == ctl_ff[5] && event_pin_one == !ctl_ff[5])
    else $error("trigger routed to wrong pin");
  pin_hold_a: assert property (
    (event_pin_one || event_pin_two) && !reg_wr && !$past(reg_wr)
    |=> $stable({event_pin_one, event_pin_two}))
    else $error("event pin changed without a write");
endmodule : sample_queue_props

bind sample_queue_modes sample_queue_props sample_queue_props_i (
  .mclk, .rstn, .trigger_event, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
  .event_pin_one, .event_pin_two, .watermark);
`default_nettype wire

// file: test/sample_host.sv
`timescale 1ns/100ps
`default_nettype none
module sample_host (
  // clock
  input  wire logic       mclk,
  // register port
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // chip select pin
  output logic            cs_n
);
  // idle bus at time zero
  initial begin
    {reg_rd, reg_wr, reg_wdata} = '0;
    reg_addr = 8'hff;
    cs_n = 1;
  end
  // single register write, lines scrambled after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge mclk);
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask : wr
  // single register read, data one cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge mclk);
    {reg_rd, reg_addr} = {1'b0, ~a};
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd
  // burst of nb data bytes, ended at 0x38 or by chip select
  task automatic burst(input int nb, output logic [47:0] e);
    e = '0;
    @(negedge mclk);
    cs_n = 0;
    reg_rd = 1;
    for (int i = 0; i <= nb + 1; i++) begin
      if (i >= 1 && i <= nb) e[8*(i-1) +: 8] = reg_rdata;
      if (i < nb) reg_addr = sample_queue_pkg::DATA_FIRST_ADDR + 8'(i);
      else if (i == nb && nb == 6) reg_addr = sample_queue_pkg::CTL_ADDR;
      else reg_rd = 0;
      @(negedge mclk);
    end
    if (nb < 6) cs_n = 1;
    reg_addr = ~reg_addr;
    repeat (50) @(negedge mclk); // 5 us pop gap
  endtask : burst
endmodule : sample_host
`default_nettype wire

// file: test/sample_queue_modes_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, x, g) begin checks++; if ((g) !== (x)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, x, g); end end
module sample_queue_modes_tb_top;
  logic        mclk, rstn, sample_valid, trigger_event, reg_rd, reg_wr, cs_n;
  logic        event_pin_one, event_pin_two, watermark, overrun;
  logic [15:0] meas_x, meas_y, meas_z;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, st;
  logic [47:0] e;
  int          error_cnt, checks;

  sample_queue_modes sample_queue_modes_i (
    .mclk, .rstn, .sample_valid, .meas_x, .meas_y, .meas_z, .trigger_event, .reg_rd,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .cs_n, .event_pin_one, .event_pin_two,
    .watermark, .overrun);
  sample_host sample_host_i (
    .mclk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .cs_n);

  // 10 MHz clock
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  // entry as stored: z, y, x
  function automatic logic [47:0] ent(input logic [15:0] v);
    return {v + 16'h0200, v + 16'h0100, v};
  endfunction : ent
  // one sample pulse every two cycles
  task automatic push(input int n, input logic [15:0] b);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      sample_valid = 1;
      {meas_z, meas_y, meas_x} = ent(b + 16'(i));
      @(negedge mclk);
      sample_valid = 0;
    end
  endtask : push
  // trigger pulse, then the settle time
  task automatic trig;
    @(negedge mclk);
    trigger_event = 1;
    @(negedge mclk);
    trigger_event = 0;
    repeat (50) @(negedge mclk);
  endtask : trig
  // shared comparisons
  task automatic stat_chk(input logic [7:0] x);
    sample_host_i.rd(sample_queue_pkg::STATE_ADDR, st);
    `CHK("status", x, st)
  endtask : stat_chk
  task automatic pop_chk(input int nb, input logic [47:0] x);
    sample_host_i.burst(nb, e);
    `CHK("entry", x, e)
  endtask : pop_chk
  // reset state and bypass overrun
  task automatic t_bypass;
    `CHK("flags", 4'h0, {event_pin_one, event_pin_two, watermark, overrun})
    sample_host_i.rd(sample_queue_pkg::CTL_ADDR, st);
    `CHK("ctl", 8'h00, st)
    push(2, 16'h0010);
    `CHK("ovr", 1'b1, overrun)
    stat_chk(8'h00);
    sample_host_i.burst(6, e);
    `CHK("ovr", 1'b0, overrun)
  endtask : t_bypass
  // fill-once to full, short read, flush
  task automatic t_fill;
    sample_host_i.wr(sample_queue_pkg::CTL_ADDR, 8'h44);
    push(34, 16'h0000);
    stat_chk(8'h20);
    `CHK("ovr", 1'b1, overrun)
    `CHK("wm", 1'b1, watermark)
    pop_chk(6, ent(16'h0000));
    `CHK("ovr", 1'b0, overrun)
    pop_chk(1, 48'h0000_0000_0001);
    pop_chk(6, ent(16'h0002));
    stat_chk(8'h1d);
    sample_host_i.wr(sample_queue_pkg::CTL_ADDR, 8'h00);
    stat_chk(8'h00);
    `CHK("wm", 1'b0, watermark)
  endtask : t_fill
  // stream keeps newest, watermark falls on read
  task automatic t_stream;
    sample_host_i.wr(sample_queue_pkg::CTL_ADDR, 8'h9f);
    push(40, 16'h0100);
    stat_chk(8'h20);
    pop_chk(6, ent(16'h0108));
    `CHK("wm", 1'b1, watermark)
    sample_host_i.burst(6, e);
    `CHK("wm", 1'b0, watermark)
    sample_host_i.wr(sample_queue_pkg::CTL_ADDR, 8'h00);
  endtask : t_stream
  // trigger trim, one-shot, re-arm on other pin
  task automatic t_trigger;
    sample_host_i.wr(sample_queue_pkg::CTL_ADDR, 8'he3);
    push(10, 16'h0200);
    trig();
    `CHK("pins", 2'b01, {event_pin_one, event_pin_two})
    stat_chk(8'h83);
    pop_chk(6, ent(16'h0207));
    trig();
    push(40, 16'h0300);
    stat_chk(8'ha0);
    sample_host_i.wr(sample_queue_pkg::CTL_ADDR, 8'h00);
    @(negedge mclk);
    `CHK("pins", 2'b00, {event_pin_one, event_pin_two})
    sample_host_i.wr(sample_queue_pkg::CTL_ADDR, 8'hc0);
    push(5, 16'h0400);
    trig();
    `CHK("pins", 2'b10, {event_pin_one, event_pin_two})
    `CHK("wm", 1'b1, watermark)
    stat_chk(8'h80);
  endtask : t_trigger
  // counts and verdict
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // main sequence
  initial begin
    {rstn, sample_valid, trigger_event, meas_x, meas_y, meas_z} = '0;
    error_cnt = 0;
    checks = 0;
    repeat (5) @(negedge mclk);
    rstn = 1;
    t_bypass();
    t_fill();
    t_stream();
    t_trigger();
    results();
  end
endmodule : sample_queue_modes_tb_top
`default_nettype wire
